// ### rtl/ibrp_port.sv
`timescale 1ns/1ps

// ----------------------------------------
// Write buffer
// ----------------------------------------
module ibrp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Fill side
   input wire logic fillValid,
   output logic fillReady,
   input wire logic [WIDTH-1:0] fillData,
   // Drain side
   output logic drainValid,
   input wire logic drainReady,
   output logic [WIDTH-1:0] drainData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
   logic [AW:0] count_ff, nxt_count;
   logic push, pop;

   // Honest full and empty from the count
   always_comb begin
      fillReady = (count_ff != (AW+1)'(DEPTH));
      drainValid = (count_ff != '0);
      drainData = store[rdPtr_ff];
      push = fillValid && fillReady;
      pop = drainValid && drainReady;
      nxt_wrPtr = push ? wrPtr_ff + 1'b1 : wrPtr_ff;
      nxt_rdPtr = pop ? rdPtr_ff + 1'b1 : rdPtr_ff;
      nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clock) begin
      if (push) begin
         store[wrPtr_ff] <= fillData;
      end
   end
endmodule

// What this block does
// RULE1: An 8-bit pointer at offset 10h picks the scratch byte reached through the window.
// RULE2: The scratch RAM covers bytes 00h to FFh so every pointer value is a real byte.
// RULE3: Reading the window at 13h returns the byte at the pointer.
// RULE4: Writing the window at 13h stores the byte at the pointer.
// RULE5: With burst off, window accesses keep hitting one byte until the pointer is rewritten.
// RULE6: With burst on the pointer advances after window accesses, with it off it never does.
// RULE7: The host loads the start address into the pointer and then walks the window.
// RULE8: The advance happens at the strobe release, only for window accesses.
// RULE9: After FFh the pointer wraps to 00h.
// RULE10: Each window access uses the pointer held before the strobe edge.
// RULE11: Reading the pointer returns its value and changes nothing.
module ibrp_port (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Host byte bus
   input wire logic csN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic [4:0] addr,
   input wire logic [7:0] busData,
   output logic [7:0] readData,
   output logic dataOe,
   // Control bit
   input wire logic burstIncrementEnable
);
   ibrp_pkg::ibrp_bus_type busIn, sync1_ff, sync2_ff;
   logic burst1_ff, burst2_ff;
   ibrp_pkg::ibrp_state_type state_ff, nxt_state;
   logic [7:0] ptr_ff, nxt_ptr, wrData_ff, nxt_wrData, dataOut_ff, nxt_dataOut;
   logic [4:0] accAddr_ff, nxt_accAddr;
   logic dataOe_ff, nxt_dataOe;
   logic active, isWindow, ptrInc, ptrLoad, release_;
   logic pushValid, pushReady, popValid, popReady;
   ibrp_pkg::ibrp_wr_type pushData, popData;
   logic [7:0] ram [ibrp_pkg::RAM_DEPTH];
   logic [7:0] rdWord;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   assign busIn = '{csN: csN, oeN: oeN, weN: weN, addr: addr, data: busData};

   // Two stages before any logic looks
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_ff <= '{csN: 1'b1, oeN: 1'b1, weN: 1'b1, default: '0};
         sync2_ff <= '{csN: 1'b1, oeN: 1'b1, weN: 1'b1, default: '0};
         burst1_ff <= 1'b0;
         burst2_ff <= 1'b0;
      end else begin
         sync1_ff <= busIn;
         sync2_ff <= sync1_ff;
         burst1_ff <= burstIncrementEnable;
         burst2_ff <= burst1_ff;
      end
   end

   // ----------------------------------------
   // Access sequencer and pointer
   // ----------------------------------------
   assign active = !sync2_ff.csN && (!sync2_ff.oeN || !sync2_ff.weN);
   assign isWindow = (accAddr_ff == ibrp_pkg::WINDOW_OFFSET);
   assign release_ = !active;
   assign rdWord = ram[ptr_ff]; // [RULE2]

   // Next state, pointer and read data
   always_comb begin
      nxt_state = state_ff;
      nxt_accAddr = accAddr_ff;
      nxt_wrData = wrData_ff;
      nxt_dataOut = dataOut_ff;
      nxt_dataOe = dataOe_ff;
      ptrInc = 1'b0;
      ptrLoad = 1'b0;
      pushValid = 1'b0;
      pushData = '{addr: ptr_ff, data: wrData_ff}; // [RULE10]
      unique case (state_ff)
         ibrp_pkg::ST_IDLE: begin
            if (active) begin
               nxt_accAddr = sync2_ff.addr;
               nxt_wrData = sync2_ff.data;
               nxt_state = !sync2_ff.weN ? ibrp_pkg::ST_WRHOLD : ibrp_pkg::ST_RDWAIT;
            end
         end
         ibrp_pkg::ST_RDWAIT: begin
            if (release_) begin
               ptrInc = isWindow && burst2_ff; // [RULE8]
               nxt_state = ibrp_pkg::ST_IDLE;
            end else if (!popValid) begin
               // Reads wait for buffered writes to land
               nxt_dataOe = isWindow || (accAddr_ff == ibrp_pkg::PTR_OFFSET);
               nxt_dataOut = isWindow ? rdWord : ptr_ff; // [RULE3] [RULE11]
               if (!nxt_dataOe) begin
                  nxt_dataOut = ibrp_pkg::IDLE_DATA;
               end
               nxt_state = ibrp_pkg::ST_RDHOLD;
            end
         end
         ibrp_pkg::ST_RDHOLD: begin
            if (release_) begin
               nxt_dataOe = 1'b0;
               nxt_dataOut = ibrp_pkg::IDLE_DATA;
               ptrInc = isWindow && burst2_ff; // [RULE6] [RULE8]
               nxt_state = ibrp_pkg::ST_IDLE;
            end
         end
         ibrp_pkg::ST_WRHOLD: begin
            if (active) begin
               nxt_wrData = sync2_ff.data;
            end else begin
               nxt_state = ibrp_pkg::ST_WRPUSH;
            end
         end
         ibrp_pkg::ST_WRPUSH: begin
            if (accAddr_ff == ibrp_pkg::PTR_OFFSET) begin
               ptrLoad = 1'b1; // [RULE1]
               nxt_state = ibrp_pkg::ST_IDLE;
            end else if (isWindow) begin
               pushValid = 1'b1; // [RULE4]
               if (pushReady) begin
                  ptrInc = burst2_ff; // [RULE6] [RULE8]
                  nxt_state = ibrp_pkg::ST_IDLE;
               end
            end else begin
               nxt_state = ibrp_pkg::ST_IDLE;
            end
         end
      endcase
      // Pointer moves only on load or burst step, wrapping at the top
      if (ptrLoad) begin
         nxt_ptr = wrData_ff;
      end else if (ptrInc) begin
         nxt_ptr = ptr_ff + ibrp_pkg::PTR_STEP; // [RULE9] [RULE5]
      end else begin
         nxt_ptr = ptr_ff;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ibrp_pkg::ST_IDLE;
         ptr_ff <= ibrp_pkg::PTR_RESET;
         accAddr_ff <= '0;
         wrData_ff <= ibrp_pkg::IDLE_DATA;
         dataOut_ff <= ibrp_pkg::IDLE_DATA;
         dataOe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ptr_ff <= nxt_ptr;
         accAddr_ff <= nxt_accAddr;
         wrData_ff <= nxt_wrData;
         dataOut_ff <= nxt_dataOut;
         dataOe_ff <= nxt_dataOe;
      end
   end

   assign readData = dataOut_ff;
   assign dataOe = dataOe_ff;

   // ----------------------------------------
   // Write buffer and scratch RAM
   // ----------------------------------------
   ibrp_fifo #(
      .WIDTH($bits(ibrp_pkg::ibrp_wr_type)),
      .DEPTH(ibrp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .nrst(nrst),
      .fillValid(pushValid),
      .fillReady(pushReady),
      .fillData(pushData),
      .drainValid(popValid),
      .drainReady(popReady),
      .drainData(popData)
   );

   // Drain stalls while a read drives the bus
   assign popReady = (state_ff != ibrp_pkg::ST_RDHOLD);

   // Store drained bytes
   always_ff @(posedge clock) begin
      if (popValid && popReady) begin
         ram[popData.addr] <= popData.data; // [RULE4]
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_ptrLoad;
      @(posedge clock) disable iff (!nrst)
      ptrLoad |=> (ptr_ff == $past(wrData_ff));
   endproperty
   a_ptrLoad: assert property (p_ptrLoad) else $error("pointer not loaded"); // [RULE1]

   property p_ramWrite;
      @(posedge clock) disable iff (!nrst)
      (popValid && popReady) |=> (ram[$past(popData.addr)] == $past(popData.data));
   endproperty
   a_ramWrite: assert property (p_ramWrite) else $error("byte not stored"); // [RULE2]

   property p_windowRead;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ibrp_pkg::ST_RDWAIT && active && !popValid && isWindow)
      |=> (dataOe_ff && dataOut_ff == $past(rdWord));
   endproperty
   a_windowRead: assert property (p_windowRead) else $error("window read wrong"); // [RULE3]

   property p_windowPush;
      @(posedge clock) disable iff (!nrst)
      (pushValid && pushReady) |-> ##[1:40] (popValid && popReady);
   endproperty
   a_windowPush: assert property (p_windowPush) else $error("write not drained"); // [RULE4]

   property p_noBurstHold;
      @(posedge clock) disable iff (!nrst)
      (!burst2_ff && !ptrLoad) |=> $stable(ptr_ff);
   endproperty
   a_noBurstHold: assert property (p_noBurstHold) else $error("pointer moved"); // [RULE5]

   property p_burstStep;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ibrp_pkg::ST_RDHOLD && release_ && isWindow && burst2_ff)
      |=> (ptr_ff == $past(ptr_ff) + ibrp_pkg::PTR_STEP);
   endproperty
   a_burstStep: assert property (p_burstStep) else $error("no burst step"); // [RULE6]

   property p_stepOnlyWindow;
      @(posedge clock) disable iff (!nrst)
      ptrInc |-> (isWindow && release_);
   endproperty
   a_stepOnlyWindow: assert property (p_stepOnlyWindow) else $error("stray step"); // [RULE8]

   property p_wrap;
      @(posedge clock) disable iff (!nrst)
      (ptrInc && ptr_ff == ibrp_pkg::PTR_TOP) |=> (ptr_ff == ibrp_pkg::PTR_BOTTOM);
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // [RULE9]

   property p_oldPointer;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ibrp_pkg::ST_RDHOLD && isWindow) |-> (dataOut_ff == ram[ptr_ff]);
   endproperty
   a_oldPointer: assert property (p_oldPointer) else $error("access used new pointer"); // [RULE10]

   property p_ptrRead;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ibrp_pkg::ST_RDWAIT && active && !popValid
       && accAddr_ff == ibrp_pkg::PTR_OFFSET)
      |=> (dataOut_ff == ptr_ff && $stable(ptr_ff));
   endproperty
   a_ptrRead: assert property (p_ptrRead) else $error("pointer read wrong"); // [RULE11]
endmodule

// ### shared/ibrp_pkg.sv
package ibrp_pkg;
   // ----------------------------------------
   // Register map and field layout
   // ----------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int RAM_DEPTH = 256;
   localparam int FIFO_DEPTH = 32;
   localparam logic [4:0] PTR_OFFSET = 5'h10;
   localparam logic [4:0] WINDOW_OFFSET = 5'h13;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [7:0] PTR_TOP = 8'hFF;
   localparam logic [7:0] PTR_BOTTOM = 8'h00;
   localparam logic [7:0] IDLE_DATA = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } ibrp_wr_type;

   typedef struct packed {
      logic csN;
      logic oeN;
      logic weN;
      logic [4:0] addr;
      logic [7:0] data;
   } ibrp_bus_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RDWAIT, ST_RDHOLD, ST_WRHOLD, ST_WRPUSH
   } ibrp_state_type;
endpackage

// ### test/ibrp_host_model.sv
`timescale 1ns/1ps

// Host processor on the asynchronous byte bus
module ibrp_host_model (
   // Clock for pacing
   input wire logic clock,
   // Host byte bus
   output logic csN,
   output logic oeN,
   output logic weN,
   output logic [4:0] addr,
   output logic [7:0] busData,
   // Device answer
   input wire logic [7:0] readData,
   input wire logic dataOe
);
   // Idle bus at time zero
   initial begin
      csN = 1'b1;
      oeN = 1'b1;
      weN = 1'b1;
      addr = 5'h00;
      busData = 8'hFF;
   end

   // Write strobe held 6 cycles, then 6 idle cycles
   task automatic busWrite(input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      addr = a;
      busData = d;
      csN = 1'b0;
      weN = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      csN = 1'b1;
      weN = 1'b1;
      busData = ~d; // Released data shows the inverse
      repeat (6) @(posedge clock);
      #1;
   endtask

   // Read strobe held until the answer is seen, bounded wait
   task automatic busRead(input logic [4:0] a, output logic [7:0] d, output logic ok);
      int n;
      ok = 1'b0;
      d = 8'h00;
      @(posedge clock);
      #1;
      addr = a;
      csN = 1'b0;
      oeN = 1'b0;
      // Answer looked at once settled after the edge
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clock);
         #1;
         if (n >= 5 && dataOe === 1'b1) begin
            ok = 1'b1;
            d = readData;
         end
      end
      csN = 1'b1;
      oeN = 1'b1;
      repeat (6) @(posedge clock);
      #1;
   endtask
endmodule

// ### test/ibrp_port_bench.sv
`timescale 1ns/1ps

module ibrp_port_bench;
   logic clock;
   logic nrst;
   logic burstIncrementEnable;
   logic csN;
   logic oeN;
   logic weN;
   logic [4:0] addr;
   logic [7:0] busData;
   logic [7:0] readData;
   logic dataOe;
   logic [7:0] refRam [256];
   logic [7:0] refPtr;
   logic [7:0] got;
   logic ok;
   int mismatches = 0;
   int checksDone = 0;
   int cycles = 0;
   int seed;

   // ----------------------------------------
   // Device and host
   // ----------------------------------------
   ibrp_port i_dut (.clock, .nrst, .csN, .oeN, .weN, .addr, .busData, .readData, .dataOe,
      .burstIncrementEnable);
   ibrp_host_model i_host (.clock, .csN, .oeN, .weN, .addr, .busData, .readData, .dataOe);

   // ----------------------------------------
   // Expectations and checks
   // ----------------------------------------
   function automatic logic [7:0] stepPtr(input logic [7:0] p, input logic b);
      return b ? p + 8'h01 : p;
   endfunction

   task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checksDone++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finalReport();
      $display("Checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Register accesses with the reference kept in step
   task automatic ptrWrite(input logic [7:0] p);
      i_host.busWrite(ibrp_pkg::PTR_OFFSET, p);
      refPtr = p;
   endtask

   task automatic ptrRead();
      i_host.busRead(ibrp_pkg::PTR_OFFSET, got, ok);
      chkByte("pointer answer", 8'h01, {7'h00, ok});
      chkByte("pointer", refPtr, got);
   endtask

   task automatic winWrite(input logic [7:0] d);
      i_host.busWrite(ibrp_pkg::WINDOW_OFFSET, d);
      refRam[refPtr] = d;
      refPtr = stepPtr(refPtr, burstIncrementEnable);
   endtask

   task automatic winRead();
      i_host.busRead(ibrp_pkg::WINDOW_OFFSET, got, ok);
      chkByte("window answer", 8'h01, {7'h00, ok});
      chkByte("window", refRam[refPtr], got);
      refPtr = stepPtr(refPtr, burstIncrementEnable);
   endtask

   // Clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         finalReport();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'hCD5D9402;
      nrst = 1'b0;
      burstIncrementEnable = 1'b0;
      refPtr = ibrp_pkg::PTR_RESET;
      repeat (8) @(posedge clock);
      #1;
      nrst = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      ptrRead();
      // Fill all 256 bytes with a burst that wraps
      burstIncrementEnable = 1'b1;
      ptrWrite(8'h80);
      for (int i = 0; i < 256; i++)
         winWrite(8'($random(seed)));
      ptrRead();
      // Reads across the top of the space
      ptrWrite(8'hFE);
      repeat (3) winRead();
      ptrRead();
      // Other offsets neither answer nor step the pointer
      i_host.busRead(5'h11, got, ok);
      chkByte("unmapped answer", 8'h00, {7'h00, ok});
      i_host.busWrite(5'h12, 8'hA5);
      ptrRead();
      // Burst off keeps one byte
      burstIncrementEnable = 1'b0;
      ptrWrite(8'hFF);
      winWrite(8'h5A);
      winRead();
      winRead();
      ptrRead();
      // Random mix of accesses and burst settings
      for (int i = 0; i < 150; i++) begin
         burstIncrementEnable = 1'($random(seed));
         case (2'($random(seed)))
            2'd0: ptrWrite(8'($random(seed)));
            2'd1: winWrite(8'($random(seed)));
            2'd2: winRead();
            default: ptrRead();
         endcase
      end
      finalReport();
   end
endmodule
